// *** core/eeseq_defines.svh ***
// Constants for the data EEPROM erase/program sequencer
`ifndef EESEQ_DEFINES_SVH
`define EESEQ_DEFINES_SVH

// Control register field positions
`define EESEQ_GO_BIT 15
`define EESEQ_PERMIT_BIT 14
`define EESEQ_ERR_BIT 13
`define EESEQ_STATUS_BIT 8
`define EESEQ_OP_MSB 6
`define EESEQ_OP_W 7
`define EESEQ_CTRL_RESET 16'h0000

// Unlock key values
`define EESEQ_KEY1 8'h55
`define EESEQ_KEY2 8'hAA

// Operation codes (low seven bits of the control value)
`define EESEQ_OP_WORD_ERASE 7'h44
`define EESEQ_OP_WORD_PROG 7'h04
`define EESEQ_OP_BLOCK_ERASE 7'h45
`define EESEQ_OP_BLOCK_PROG 7'h05

// Cycle timing
`define EESEQ_CYCLE_NS 2000000
`define EESEQ_CLK_NS 25
`define EESEQ_CYCLE_COUNT (`EESEQ_CYCLE_NS / `EESEQ_CLK_NS)

// Latch geometry
`define EESEQ_LATCHES 16
`define EESEQ_LATCH_IDX_W 4
`define EESEQ_IDX_LSB 1

// Address register split
`define EESEQ_ADDR_LOW_W 16
`define EESEQ_ADDR_HIGH_LSB 16
`define EESEQ_ADDR_HIGH_W 8

`endif

// *** core/eeseq_pkg.sv ***
// Types for the data EEPROM erase/program sequencer
package eeseq_pkg;
   typedef enum logic [1:0] {
      EESEQ_UNLOCK_IDLE,
      EESEQ_UNLOCK_KEY1,
      EESEQ_UNLOCK_ARMED
   } eeseq_unlock_t;

   typedef enum logic [1:0] {
      EESEQ_IDLE,
      EESEQ_RUN,
      EESEQ_DONE
   } eeseq_state_t;

   typedef enum logic [1:0] {
      EESEQ_KIND_ERASE,
      EESEQ_KIND_PROG,
      EESEQ_KIND_NONE
   } eeseq_kind_t;
endpackage

// *** core/eeseq_sequencer.sv ***
// Data EEPROM erase/program sequencer with unlock key and write latches
`timescale 1ns/1ps
`include "eeseq_defines.svh"

// Behaviour
// - A started cycle ends by itself after about 2 ms.
// - The processor is never stalled; no stall output exists.
// - Key 0x55 then 0xAA then go bit, per word, or no start.
// - Go bit cannot be set while write permit is clear.
// - Permit set in the same write as go does not start.
// - Hardware never clears the write permit bit.
// - Clearing write permit mid-cycle does not stop the cycle.
// - Completion clears the go bit and sets the done flag.
// - Done flag holds until software clears it.
// - Go reads set while running; done flag is pollable.
// - Done interrupt raised only when software enables it.
// - Codes 4044 word erase, 0x4004 word program.
// - Valid go starts the cycle named by the operation field.
// - Erase targets the loaded upper and lower address registers.
// - Program needs erase first and the data placed in latches.
// - Low table write loads one latch and records its address.
// - Block program uses all sixteen latches.
// - Software can set go but never clear it.
// - Warm reset during a cycle sets the error bit; address kept.
// - Reads during a cycle return unspecified data.
module eeseq_sequencer #(
   parameter int CYCLE_COUNT = `EESEQ_CYCLE_COUNT,
   parameter int ADDR_W = 24,
   parameter int DATA_W = 16
) (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic warm_reset_n,
   // Control register write port
   input wire logic ctrl_wr,
   input wire logic [15:0] ctrl_wdata,
   input wire logic key_wr,
   input wire logic [7:0] key_wdata,
   input wire logic addr_low_wr,
   input wire logic addr_high_wr,
   input wire logic [15:0] addr_wdata,
   input wire logic done_clear,
   input wire logic done_irq_enable,
   // Table write port
   input wire logic table_write_low,
   input wire logic [ADDR_W-1:0] table_addr,
   input wire logic [DATA_W-1:0] table_wdata,
   // Register views
   output logic [15:0] nv_control_reg,
   output logic [15:0] target_addr_low,
   output logic [7:0] target_addr_high,
   output logic nv_done_flag,
   output logic done_irq,
   // Array side
   output logic array_erase,
   output logic array_prog,
   output logic array_block,
   output logic [ADDR_W-1:0] array_addr,
   output logic cycle_end,
   output logic [DATA_W-1:0] latch_data [`EESEQ_LATCHES]
);
   import eeseq_pkg::*;

   initial begin
      if (CYCLE_COUNT < 2) begin
         $error("eeseq_sequencer: cycle count below two");
      end
      if (ADDR_W != `EESEQ_ADDR_HIGH_LSB + `EESEQ_ADDR_HIGH_W) begin
         $error("eeseq_sequencer: address width must match the address registers");
      end
      if (DATA_W < 1) begin
         $error("eeseq_sequencer: data width below one");
      end
   end

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   // Decode operation field into erase, program or none
   function automatic eeseq_kind_t op_kind(input logic [`EESEQ_OP_W-1:0] op);
      unique case (op)
         `EESEQ_OP_WORD_ERASE, `EESEQ_OP_BLOCK_ERASE: op_kind = EESEQ_KIND_ERASE;
         `EESEQ_OP_WORD_PROG, `EESEQ_OP_BLOCK_PROG: op_kind = EESEQ_KIND_PROG;
         default: op_kind = EESEQ_KIND_NONE;
      endcase
   endfunction

   // Block operations are the odd codes
   function automatic logic op_block(input logic [`EESEQ_OP_W-1:0] op);
      op_block = (op == `EESEQ_OP_BLOCK_ERASE) || (op == `EESEQ_OP_BLOCK_PROG);
   endfunction

   // Timer width and last count of a cycle
   localparam int TIMER_W = $clog2(CYCLE_COUNT);
   localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(CYCLE_COUNT - 1);

   eeseq_unlock_t unlock;
   eeseq_state_t state;
   logic go;
   logic permit;
   logic abort_err;
   logic status;
   logic [`EESEQ_OP_W-1:0] op_sel;
   logic [TIMER_W-1:0] timer;
   logic start;
   logic running;
   logic finish;

   assign running = (state == EESEQ_RUN);
   assign finish = running && (timer == TIMER_LAST);
   // Start needs armed key, permit from an earlier write, a legal op
   assign start = ctrl_wr && ctrl_wdata[`EESEQ_GO_BIT] && (unlock == EESEQ_UNLOCK_ARMED)
      && permit && !running && (op_kind(op_sel) != EESEQ_KIND_NONE)
      && warm_reset_n;

   // ----------------------------------------------------------------
   // Unlock sequence
   // ----------------------------------------------------------------
   // Key tracker; any other control write or wrong key disarms
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         unlock <= EESEQ_UNLOCK_IDLE;
      end else if (key_wr) begin
         if (key_wdata == `EESEQ_KEY1) begin
            unlock <= EESEQ_UNLOCK_KEY1;
         end else if (key_wdata == `EESEQ_KEY2 && unlock == EESEQ_UNLOCK_KEY1) begin
            unlock <= EESEQ_UNLOCK_ARMED;
         end else begin
            unlock <= EESEQ_UNLOCK_IDLE;
         end
      end else if (ctrl_wr) begin
         unlock <= EESEQ_UNLOCK_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Write permit follows software only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         permit <= 1'b0;
      end else if (ctrl_wr) begin
         permit <= ctrl_wdata[`EESEQ_PERMIT_BIT];
      end
   end

   // Operation field frozen while a cycle runs
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         op_sel <= '0;
      end else if (ctrl_wr && !running) begin
         op_sel <= ctrl_wdata[`EESEQ_OP_MSB:0];
      end
   end

   // Go bit: set by valid start, cleared by completion or abort only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         go <= 1'b0;
      end else if (finish) begin
         go <= 1'b0;
      end else if (!warm_reset_n) begin
         go <= 1'b0;
      end else if (start) begin
         go <= 1'b1;
      end
   end

   // Error bit: a warm reset during a cycle flags the abort
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         abort_err <= 1'b0;
      end else if (!warm_reset_n && running) begin
         abort_err <= 1'b1;
      end else if (ctrl_wr) begin
         abort_err <= ctrl_wdata[`EESEQ_ERR_BIT];
      end
   end

   // Status bit shows a cycle in progress
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         status <= 1'b0;
      end else begin
         status <= start || (running && !finish && warm_reset_n);
      end
   end

   // ----------------------------------------------------------------
   // Cycle engine
   // ----------------------------------------------------------------
   // Runs without stalling the core; permit not looked at once running
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= EESEQ_IDLE;
      end else if (!warm_reset_n) begin
         state <= EESEQ_IDLE;
      end else begin
         unique case (state)
            EESEQ_IDLE: if (start) begin
               state <= EESEQ_RUN;
            end
            EESEQ_RUN: if (finish) begin
               state <= EESEQ_DONE;
            end
            EESEQ_DONE: state <= EESEQ_IDLE;
         endcase
      end
   end

   // Cycle timer with configurable terminal count
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         timer <= '0;
      end else if (!running || !warm_reset_n) begin
         timer <= '0;
      end else begin
         timer <= timer + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Address registers and latches
   // ----------------------------------------------------------------
   // Low address word; keeps its value across warm reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         target_addr_low <= '0;
      end else if (table_write_low) begin
         target_addr_low <= table_addr[`EESEQ_ADDR_LOW_W-1:0];
      end else if (addr_low_wr) begin
         target_addr_low <= addr_wdata;
      end
   end

   // High address byte, same priority as the low word
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         target_addr_high <= '0;
      end else if (table_write_low) begin
         target_addr_high <= table_addr[`EESEQ_ADDR_HIGH_LSB +: `EESEQ_ADDR_HIGH_W];
      end else if (addr_high_wr) begin
         target_addr_high <= addr_wdata[`EESEQ_ADDR_HIGH_W-1:0];
      end
   end

   // One latch per low table write, indexed by word address
   genvar g;
   generate
      for (g = 0; g < `EESEQ_LATCHES; g++) begin : g_latch
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               latch_data[g] <= '0;
            end else if (table_write_low && table_addr[`EESEQ_IDX_LSB +:
                  `EESEQ_LATCH_IDX_W] == `EESEQ_LATCH_IDX_W'(g)) begin
               latch_data[g] <= table_wdata;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Done flag: set wins over software clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         nv_done_flag <= 1'b0;
      end else if (finish) begin
         nv_done_flag <= 1'b1;
      end else if (done_clear) begin
         nv_done_flag <= 1'b0;
      end
   end

   // Registered view of the control word
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         nv_control_reg <= `EESEQ_CTRL_RESET;
      end else begin
         nv_control_reg <= '0;
         nv_control_reg[`EESEQ_GO_BIT] <= go;
         nv_control_reg[`EESEQ_PERMIT_BIT] <= permit;
         nv_control_reg[`EESEQ_ERR_BIT] <= abort_err;
         nv_control_reg[`EESEQ_STATUS_BIT] <= status;
         nv_control_reg[`EESEQ_OP_MSB:0] <= op_sel;
      end
   end

   // Done interrupt gated by software enable
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         done_irq <= 1'b0;
      end else begin
         done_irq <= (nv_done_flag || finish) && done_irq_enable
            && !(done_clear && !finish);
      end
   end

   // Array strobes: erase or program level during a cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         array_erase <= 1'b0;
         array_prog <= 1'b0;
         array_block <= 1'b0;
      end else if (start) begin
         array_erase <= (op_kind(op_sel) == EESEQ_KIND_ERASE);
         array_prog <= (op_kind(op_sel) == EESEQ_KIND_PROG);
         array_block <= op_block(op_sel);
      end else if (finish || !warm_reset_n) begin
         array_erase <= 1'b0;
         array_prog <= 1'b0;
      end
   end

   // Target captured at start, so later address writes cannot move it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         array_addr <= '0;
      end else if (start) begin
         array_addr <= {target_addr_high, target_addr_low};
      end
   end

   // End pulse one cycle after the last count
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cycle_end <= 1'b0;
      end else begin
         cycle_end <= finish;
      end
   end
   // Array read path is not forwarded here; reads mid-cycle are undefined.
endmodule // eeseq_sequencer

// *** sim/eeseq_checker.sv ***
// Port assertions for the EEPROM sequencer
`timescale 1ns/1ps
module eeseq_checker #(
   parameter int CYCLE_COUNT = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Inputs watched
   input wire logic ctrl_wr,
   input wire logic done_clear,
   input wire logic done_irq_enable,
   // Outputs watched
   input wire logic [15:0] nv_control_reg,
   input wire logic nv_done_flag,
   input wire logic done_irq,
   input wire logic array_erase,
   input wire logic array_prog,
   input wire logic cycle_end
);
   localparam int CYC = CYCLE_COUNT;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Launch of a cycle and its timed end, or an abort
   sequence s_launch;
      $rose(array_erase || array_prog);
   endsequence
   sequence s_finish;
      ##CYC (cycle_end || nv_control_reg[13]);
   endsequence
   chk_cycle_timed: assert property (s_launch |-> s_finish) else $error("late end");
   chk_go_permit: assert property ($rose(nv_control_reg[15]) |-> $past(nv_control_reg[14]))
      else $error("go rose without permit");
   chk_go_held: assert property ($rose(nv_control_reg[15]) |-> nv_control_reg[15][*5])
      else $error("go dropped early");
   chk_end_done: assert property ($fell(nv_control_reg[15]) && !nv_control_reg[13]
      |-> nv_done_flag) else $error("go fell without done");
   chk_done_sticky: assert property (nv_done_flag && !done_clear |=> nv_done_flag)
      else $error("done flag lost");
   chk_permit_kept: assert property ((!ctrl_wr)[*2] |=> $stable(nv_control_reg[14]))
      else $error("permit changed by itself");
   chk_irq_gated: assert property (done_irq |-> $past(done_irq_enable))
      else $error("irq while disabled");
   chk_op_frozen: assert property (nv_control_reg[15][*2] |-> $stable(nv_control_reg[6:0]))
      else $error("op changed while running");
endmodule // eeseq_checker

bind eeseq_sequencer eeseq_checker #(.CYCLE_COUNT(CYCLE_COUNT)) chk (.clk_sys(clk_sys),
   .reset_n(reset_n), .ctrl_wr(ctrl_wr), .done_clear(done_clear),
   .done_irq_enable(done_irq_enable), .nv_control_reg(nv_control_reg),
   .nv_done_flag(nv_done_flag), .done_irq(done_irq), .array_erase(array_erase),
   .array_prog(array_prog), .cycle_end(cycle_end));

// *** sim/eeseq_cpu_model.sv ***
// Processor model issuing register and table writes
`timescale 1ns/1ps
module eeseq_cpu_model (
   // Clock
   input wire logic clk_sys,
   // Strobes
   output logic ctrl_wr,
   output logic key_wr,
   output logic addr_low_wr,
   output logic addr_high_wr,
   output logic table_write_low,
   output logic done_clear,
   // Data
   output logic [15:0] ctrl_wdata,
   output logic [7:0] key_wdata,
   output logic [15:0] addr_wdata,
   output logic [23:0] table_addr,
   output logic [15:0] table_wdata
);
   // Idle bus at time zero
   initial begin
      {done_clear, table_write_low, addr_high_wr, addr_low_wr, key_wr, ctrl_wr} = 6'h00;
      {ctrl_wdata, key_wdata, addr_wdata, table_addr, table_wdata} = 80'h0;
   end
   // One write: strobe for one cycle, data lines scrambled once released
   task automatic wr(input int sel, input logic [23:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      #1;
      {ctrl_wdata, addr_wdata, table_wdata, key_wdata, table_addr} = {d, d, d, d[7:0], a};
      {done_clear, table_write_low, addr_high_wr, addr_low_wr, key_wr, ctrl_wr} = 6'h01 << sel;
      @(posedge clk_sys);
      #1;
      {done_clear, table_write_low, addr_high_wr, addr_low_wr, key_wr, ctrl_wr} = 6'h00;
      {ctrl_wdata, addr_wdata, table_wdata, key_wdata, table_addr} = ~{d, d, d, d[7:0], a};
   endtask
   // Key pair then go write; the model never interrupts this run
   task automatic unlock_go(input logic [15:0] c);
      wr(1, 24'h0, 16'h0055);
      wr(1, 24'h0, 16'h00AA);
      wr(0, 24'h0, c);
   endtask
endmodule // eeseq_cpu_model

// *** sim/testbench.sv ***
// Self-checking bench for the EEPROM sequencer
`timescale 1ns/1ps
module testbench;
   import eeseq_pkg::*;
   logic clk_sys, reset_n, warm_reset_n, done_irq_enable;
   logic ctrl_wr, key_wr, addr_low_wr, addr_high_wr, done_clear, table_write_low;
   logic [15:0] ctrl_wdata, addr_wdata, table_wdata, nv_control_reg, target_addr_low;
   logic [7:0] key_wdata, target_addr_high;
   logic [23:0] table_addr, array_addr;
   logic nv_done_flag, done_irq, array_erase, array_prog, array_block, cycle_end;
   logic [15:0] latch_data [16];
   int n_errors = 0;
   int compares = 0;
   eeseq_cpu_model cpu (.clk_sys, .ctrl_wr, .key_wr, .addr_low_wr, .addr_high_wr,
      .table_write_low, .done_clear, .ctrl_wdata, .key_wdata, .addr_wdata, .table_addr,
      .table_wdata);
   eeseq_sequencer #(.CYCLE_COUNT(8)) uut (.clk_sys, .reset_n, .warm_reset_n, .ctrl_wr,
      .ctrl_wdata, .key_wr, .key_wdata, .addr_low_wr, .addr_high_wr, .addr_wdata, .done_clear,
      .done_irq_enable, .table_write_low, .table_addr, .table_wdata, .nv_control_reg,
      .target_addr_low, .target_addr_high, .nv_done_flag, .done_irq, .array_erase, .array_prog,
      .array_block, .array_addr, .cycle_end, .latch_data);
   // 40 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Bounded wait for the end pulse
   task automatic wait_end();
      bit seen;
      seen = 1'b0;
      for (int k = 0; k < 40 && !seen; k++) begin
         @(posedge clk_sys);
         #1;
         seen = (cycle_end === 1'b1);
      end
      chk("cycle end", 32'h1, 32'(seen));
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #(25 * 4000);
      n_errors++;
      stop_test();
   end
   // Tests
   initial begin
      reset_n = 1'b0;
      warm_reset_n = 1'b1;
      done_irq_enable = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      chk("control reset", 32'h0, nv_control_reg);
      cpu.unlock_go(16'hC044);
      cpu.wr(1, 24'h0, 16'h00AA);
      cpu.wr(1, 24'h0, 16'h0055);
      cpu.wr(0, 24'h0, 16'hC044);
      cpu.unlock_go(16'h4044);
      cpu.wr(0, 24'h0, 16'hC044);
      settle(3);
      chk("go refused", 32'h0, nv_control_reg[15]);
      $display("end of test refusals");
      cpu.wr(3, 24'h0, 16'h007F);
      cpu.wr(2, 24'h0, 16'hF010);
      cpu.unlock_go(16'hC044);
      chk("erase strobe", 32'h1, array_erase);
      chk("erase addr", 32'h7FF010, array_addr);
      cpu.wr(0, 24'h0, 16'h0044);
      settle(1);
      chk("go kept", 32'h1, nv_control_reg[15]);
      wait_end();
      settle(1);
      chk("go cleared", 32'h0, nv_control_reg[15]);
      chk("done set", 32'h1, nv_done_flag);
      settle(3);
      chk("done held", 32'h1, nv_done_flag);
      chk("irq off", 32'h0, done_irq);
      cpu.wr(5, 24'h0, 16'h0000);
      settle(1);
      chk("done cleared", 32'h0, nv_done_flag);
      $display("end of test word erase");
      done_irq_enable = 1'b1;
      cpu.wr(4, 24'h7FF02A, 16'h1234);
      settle(1);
      chk("latch 5", 32'h1234, latch_data[5]);
      chk("addr low", 32'hF02A, target_addr_low);
      chk("addr high", 32'h7F, target_addr_high);
      cpu.wr(0, 24'h0, 16'h4004);
      cpu.unlock_go(16'hC004);
      chk("prog strobe", 32'h2, {array_prog, array_block});
      chk("prog addr", 32'h7FF02A, array_addr);
      wait_end();
      settle(1);
      chk("irq on", 32'h1, done_irq);
      chk("permit kept", 32'h1, nv_control_reg[14]);
      cpu.wr(5, 24'h0, 16'h0000);
      $display("end of test word program");
      for (int i = 0; i < 16; i++) cpu.wr(4, 24'h7FF040 + 24'(2 * i), 16'hA000 + 16'(i));
      cpu.wr(0, 24'h0, 16'h4005);
      cpu.unlock_go(16'hC005);
      chk("block strobe", 32'h3, {array_prog, array_block});
      chk("latch 15", 32'hA00F, latch_data[15]);
      wait_end();
      cpu.wr(5, 24'h0, 16'h0000);
      $display("end of test block program");
      cpu.wr(0, 24'h0, 16'h4044);
      cpu.unlock_go(16'hC044);
      chk("abort erase strobe", 32'h1, array_erase);
      settle(5);
      warm_reset_n = 1'b0;
      settle(1);
      warm_reset_n = 1'b1;
      settle(3);
      chk("abort error", 32'h1, nv_control_reg[13]);
      chk("go dropped", 32'h0, nv_control_reg[15]);
      chk("no done on abort", 32'h0, nv_done_flag);
      chk("addr kept", 32'hF05E, target_addr_low);
      cpu.wr(0, 24'h0, 16'h0000);
      $display("end of test abort");
      stop_test();
   end
endmodule // testbench
